// *** hdl/cfg_ctrl_pkg.sv ***
package cfg_ctrl_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          EV_W            = 6;

  // Register offsets
  localparam logic [7:0]  OFS_CONFIG      = 8'h00;
  localparam logic [7:0]  OFS_EV_STATUS   = 8'h04;
  localparam logic [7:0]  OFS_EV_MASK     = 8'h08;

  // Field positions of config_and_control
  localparam int          BIT_THREAD_ANY  = 0;
  localparam int          BIT_UNPRIV_TRIG = 1;
  localparam int          BIT_UNALIGN     = 3;
  localparam int          BIT_DIV_ZERO    = 4;
  localparam int          BIT_FAULT_IGN   = 8;
  localparam int          BIT_STACK_ALIGN = 9;

  // Writable bits except stack_align_8, which has its own parameter
  localparam logic [31:0] CFG_RW_MASK     = 32'h0000_011b;
  localparam logic [31:0] CFG_RESET       = 32'h0000_0000;
  localparam logic        STACK_ALIGN_RST = 1'b1;

  // Event bit positions in status and mask
  localparam int          EV_LOCKUP       = 0;
  localparam int          EV_FAULT_IGN    = 1;
  localparam int          EV_DIV_TRAP     = 2;
  localparam int          EV_UNALIGN      = 3;
  localparam int          EV_TRIG_BLOCK   = 4;
  localparam int          EV_THREAD_FAULT = 5;
  localparam logic [5:0]  EV_RESET        = 6'h00;

  // Exception frame: eight words pushed on entry
  localparam logic [31:0] FRAME_BYTES     = 32'h0000_0020;
  localparam logic [31:0] ALIGN8_PAD      = 32'h0000_0004;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } access_size_e;

  typedef struct packed {
    logic stack_align_8;
    logic high_prio_fault_ignore;
    logic divide_zero_trap;
    logic unaligned_trap;
    logic unpriv_trigger_access;
    logic thread_entry_any_prio;
  } cfg_s;

  typedef struct packed {
    logic         valid;
    logic [1:0]   addr_lo;
    access_size_e size;
    logic         multiple;
    logic         exclusive;
  } mem_access_s;

  typedef struct packed {
    logic valid;
    logic high_prio;
  } data_fault_s;

  function automatic cfg_s decode_cfg(input logic [31:0] w);
    cfg_s c;
    c.stack_align_8          = w[BIT_STACK_ALIGN];
    c.high_prio_fault_ignore = w[BIT_FAULT_IGN];
    c.divide_zero_trap       = w[BIT_DIV_ZERO];
    c.unaligned_trap         = w[BIT_UNALIGN];
    c.unpriv_trigger_access  = w[BIT_UNPRIV_TRIG];
    c.thread_entry_any_prio  = w[BIT_THREAD_ANY];
    return c;
  endfunction

  function automatic logic misaligned(input mem_access_s a);
    logic m;
    m = 1'b0;
    unique case (a.size)
      SZ_HALF: m = a.addr_lo[0];
      SZ_WORD: m = |a.addr_lo;
      default: m = 1'b0;
    endcase
    return m;
  endfunction

endpackage

// *** hdl/stack_frame_align.sv ***
`timescale 1ns/100ps
module stack_frame_align (
  input  wire logic [31:0] sp_in,
  input  wire logic        align_8,
  output logic      [31:0] frame_sp,
  output logic             adjusted
);
  import cfg_ctrl_pkg::*;

  logic [31:0] base;

  always_comb begin
    base     = sp_in - FRAME_BYTES;
    adjusted = 1'b0;
    frame_sp = base;
    if (align_8) begin // [R1]
      // Low bits dropped too, so an odd pointer still lands 8-aligned
      frame_sp = {base[31:3], 3'h0};
      adjusted = base[2];
    end
    // Clear: keep the word alignment only, never move the frame
    if (!align_8) begin // [R2]
      frame_sp = {base[31:2], 2'h0};
      adjusted = 1'b0;
    end
  end

endmodule // stack_frame_align

// *** hdl/fault_policy.sv ***
`timescale 1ns/100ps
module fault_policy (
  input  wire cfg_ctrl_pkg::cfg_s        cfg,
  input  wire cfg_ctrl_pkg::mem_access_s acc,
  input  wire cfg_ctrl_pkg::data_fault_s dfault,
  input  wire logic                      div_valid,
  input  wire logic                      div_zero,
  input  wire logic                      trig_valid,
  input  wire logic                      trig_unpriv,
  input  wire logic                      thr_valid,
  input  wire logic                      thr_nonbase,
  output logic                           go_lockup,
  output logic                           fault_ignored,
  output logic                           div_trap,
  output logic                           unalign_fault,
  output logic                           trig_grant,
  output logic                           trig_blocked,
  output logic                           thread_fault
);
  import cfg_ctrl_pkg::*;

  logic mis;

  always_comb begin
    mis           = misaligned(acc);
    go_lockup     = dfault.valid && dfault.high_prio
                    && !cfg.high_prio_fault_ignore; // [R4]
    fault_ignored = dfault.valid && dfault.high_prio
                    && cfg.high_prio_fault_ignore; // [R5]
    div_trap      = div_valid && div_zero && cfg.divide_zero_trap; // [R6]
    // Multiples and exclusives fault regardless of the trap bit
    unalign_fault = acc.valid && mis
                    && (cfg.unaligned_trap // [R7]
                        || acc.multiple || acc.exclusive); // [R8]
    trig_grant    = trig_valid
                    && (!trig_unpriv || cfg.unpriv_trigger_access); // [R9]
    trig_blocked  = trig_valid && trig_unpriv
                    && !cfg.unpriv_trigger_access; // [R9]
    thread_fault  = thr_valid && thr_nonbase
                    && !cfg.thread_entry_any_prio; // [R10] [R11]
  end

endmodule // fault_policy

// *** hdl/config_control.sv ***
// Overview of operation
// [R1] Stack alignment bit set: exception frame is 8-byte aligned, SP adjusted.
// [R2] Stack alignment bit clear: only 4-byte alignment, no SP adjustment.
// [R3] Stack alignment bit read-only or read-write by build; resets to one.
// [R4] Fault-ignore clear: precise data fault at priority -1/-2 locks up.
// [R5] Fault-ignore set: priority -1/-2 handler ignores precise data faults.
// [R6] Divide-by-zero trap bit enables or disables the divide-by-zero trap.
// [R7] Unaligned trap bit makes unaligned word or halfword accesses trap.
// [R8] Unaligned multiples and exclusives always fault, whatever the trap bit.
// [R9] Trigger access bit allows or blocks unprivileged trigger register access.
// [R10] Thread-entry bit clear: entering Thread mode above base priority faults.
// [R11] Thread-entry bit set: Thread mode allowed at any priority via return.
// [R12] Reserved bits 31:10, 7:5 and 2 read zero and ignore writes.
`timescale 1ns/100ps
module config_control #(
  parameter bit STACK_ALIGN_WRITABLE = 1'b1,
  parameter bit STACK_ALIGN_RESET    = 1'b1
) (
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  input  wire logic                      exc_entry,
  input  wire logic [31:0]               exc_sp,
  output logic      [31:0]               frame_sp,
  output logic                           frame_sp_adjusted,
  output logic                           frame_valid,
  input  wire cfg_ctrl_pkg::data_fault_s data_fault,
  input  wire cfg_ctrl_pkg::mem_access_s mem_access,
  input  wire logic                      div_valid,
  input  wire logic                      div_by_zero,
  input  wire logic                      trig_req,
  input  wire logic                      trig_unpriv,
  input  wire logic                      thread_return,
  input  wire logic                      thread_nonbase,
  output logic                           lockup,
  output logic                           fault_ignored,
  output logic                           div_trap,
  output logic                           unaligned_fault,
  output logic                           trig_grant,
  output logic                           trig_denied,
  output logic                           thread_fault,
  output logic                           irq
);
  import cfg_ctrl_pkg::*;

  // Event registers are narrower than the bus; upper bits read zero
  function automatic logic [31:0] zext_ev(input logic [EV_W-1:0] v);
    return {{(32-EV_W){1'b0}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  typedef enum logic [1:0] {
    ST_RUN    = 2'b01,
    ST_LOCKED = 2'b10
  } core_state_e;

  logic [31:0]    cfg_word_q;
  logic [31:0]    cfg_word_d;
  logic [EV_W-1:0] ev_status_q;
  logic [EV_W-1:0] ev_status_d;
  logic [EV_W-1:0] ev_mask_q;
  logic [EV_W-1:0] ev_mask_d;
  logic [31:0]    rdata_q;
  logic [31:0]    rdata_d;
  core_state_e    state_q;
  core_state_e    state_d;
  cfg_s           cfg;

  logic [31:0]    frame_sp_q;
  logic [31:0]    frame_sp_d;
  logic           frame_adj_q;
  logic           frame_adj_d;
  logic           frame_valid_q;
  logic           frame_valid_d;
  logic [6:0]     out_q;
  logic [6:0]     out_d;

  logic [31:0]    align_sp;
  logic           align_adj;
  logic           p_lockup;
  logic           p_ignored;
  logic           p_div;
  logic           p_unalign;
  logic           p_grant;
  logic           p_blocked;
  logic           p_thread;
  logic [EV_W-1:0] ev_pulse;
  logic           wr_cfg;
  logic           wr_status;
  logic           wr_mask;
  logic           running;

  assign cfg     = decode_cfg(cfg_word_q);
  assign running = (state_q == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////

  stack_frame_align u_align (
    .sp_in    (exc_sp),
    .align_8  (cfg.stack_align_8),
    .frame_sp (align_sp),
    .adjusted (align_adj)
  );

  fault_policy u_policy (
    .cfg           (cfg),
    .acc           (mem_access),
    .dfault        (data_fault),
    .div_valid     (div_valid),
    .div_zero      (div_by_zero),
    .trig_valid    (trig_req),
    .trig_unpriv   (trig_unpriv),
    .thr_valid     (thread_return),
    .thr_nonbase   (thread_nonbase),
    .go_lockup     (p_lockup),
    .fault_ignored (p_ignored),
    .div_trap      (p_div),
    .unalign_fault (p_unalign),
    .trig_grant    (p_grant),
    .trig_blocked  (p_blocked),
    .thread_fault  (p_thread)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  always_comb begin
    // Unmapped writes match no offset and change nothing
    wr_cfg    = reg_wr && (reg_addr == OFS_CONFIG);
    wr_status = reg_wr && (reg_addr == OFS_EV_STATUS);
    wr_mask   = reg_wr && (reg_addr == OFS_EV_MASK);
  end

  always_comb begin
    cfg_word_d = cfg_word_q;
    if (wr_cfg) begin
      // Reserved positions never take a one
      cfg_word_d = reg_wdata & CFG_RW_MASK; // [R12]
      if (STACK_ALIGN_WRITABLE) begin // [R3]
        cfg_word_d[BIT_STACK_ALIGN] = reg_wdata[BIT_STACK_ALIGN];
      end else begin
        // Read-only build keeps the reset value
        cfg_word_d[BIT_STACK_ALIGN] = cfg_word_q[BIT_STACK_ALIGN];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_word_q <= CFG_RESET;
      // Safe default: 8-byte frames from the first exception
      cfg_word_q[BIT_STACK_ALIGN] <= STACK_ALIGN_RESET; // [R3]
    end else begin
      cfg_word_q <= cfg_word_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; data stand for one cycle, zero otherwise

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CONFIG:    rdata_d = cfg_word_q; // [R12]
        OFS_EV_STATUS: rdata_d = zext_ev(ev_status_q);
        OFS_EV_MASK:   rdata_d = zext_ev(ev_mask_q);
        // Unmapped offsets read as zero
        default:       rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Lockup state

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN: begin
        if (p_lockup) begin // [R4]
          state_d = ST_LOCKED;
        end
      end
      // Only a reset leaves lockup
      ST_LOCKED: state_d = ST_LOCKED;
      default:   state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exception frame; a locked core pushes nothing

  always_comb begin
    frame_valid_d = running && exc_entry;
    frame_sp_d    = frame_sp_q;
    frame_adj_d   = 1'b0;
    if (running && exc_entry) begin
      frame_sp_d  = align_sp; // [R1] [R2]
      frame_adj_d = align_adj;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      frame_sp_q    <= 32'h0000_0000;
      frame_adj_q   <= 1'b0;
      frame_valid_q <= 1'b0;
    end else begin
      frame_sp_q    <= frame_sp_d;
      frame_adj_q   <= frame_adj_d;
      frame_valid_q <= frame_valid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered decisions; a locked core reports nothing new

  always_comb begin
    // Lockup level mirrors the state register
    out_d[0] = (state_d == ST_LOCKED); // [R4]
    out_d[1] = running && p_ignored; // [R5]
    out_d[2] = running && p_div; // [R6]
    out_d[3] = running && p_unalign; // [R7] [R8]
    out_d[4] = running && p_grant; // [R9]
    out_d[5] = running && p_blocked; // [R9]
    out_d[6] = running && p_thread; // [R10] [R11]
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_q <= 7'h00;
    end else begin
      out_q <= out_d;
    end
  end

  assign frame_sp          = frame_sp_q;
  assign frame_sp_adjusted = frame_adj_q;
  assign frame_valid       = frame_valid_q;
  assign lockup            = out_q[0];
  assign fault_ignored     = out_q[1];
  assign div_trap          = out_q[2];
  assign unaligned_fault   = out_q[3];
  assign trig_grant        = out_q[4];
  assign trig_denied       = out_q[5];
  assign thread_fault      = out_q[6];

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events, write one to clear; a new event beats the clear

  always_comb begin
    ev_pulse                  = '0;
    ev_pulse[EV_LOCKUP]       = out_d[0] && !out_q[0];
    ev_pulse[EV_FAULT_IGN]    = out_d[1];
    ev_pulse[EV_DIV_TRAP]     = out_d[2];
    ev_pulse[EV_UNALIGN]      = out_d[3];
    ev_pulse[EV_TRIG_BLOCK]   = out_d[5];
    ev_pulse[EV_THREAD_FAULT] = out_d[6];
    ev_status_d = ev_status_q;
    if (wr_status) begin
      ev_status_d = ev_status_q & ~reg_wdata[EV_W-1:0];
    end
    ev_status_d = ev_status_d | ev_pulse;
    ev_mask_d   = ev_mask_q;
    if (wr_mask) begin
      ev_mask_d = reg_wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ev_status_q <= EV_RESET;
      ev_mask_q   <= EV_RESET;
    end else begin
      ev_status_q <= ev_status_d;
      ev_mask_q   <= ev_mask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level output straight from the registers, no extra cycle of delay

  assign irq = |(ev_status_q & ev_mask_q);

endmodule // config_control

// *** tb/config_control_props.sv ***
`timescale 1ns/100ps
module config_control_props
  import cfg_ctrl_pkg::*;
(
  input wire logic                      ref_clk,
  input wire logic                      reset,
  input wire logic [7:0]                reg_addr,
  input wire logic [31:0]               reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [31:0]               reg_rdata,
  input wire logic                      exc_entry,
  input wire logic [31:0]               exc_sp,
  input wire logic [31:0]               frame_sp,
  input wire logic                      frame_sp_adjusted,
  input wire logic                      frame_valid,
  input wire cfg_ctrl_pkg::data_fault_s data_fault,
  input wire cfg_ctrl_pkg::mem_access_s mem_access,
  input wire logic                      div_valid,
  input wire logic                      div_by_zero,
  input wire logic                      trig_req,
  input wire logic                      trig_unpriv,
  input wire logic                      thread_return,
  input wire logic                      thread_nonbase,
  input wire logic                      lockup,
  input wire logic                      fault_ignored,
  input wire logic                      div_trap,
  input wire logic                      unaligned_fault,
  input wire logic                      trig_grant,
  input wire logic                      trig_denied,
  input wire logic                      thread_fault
);
  // Shadow of config; cfg_p is the value the core used one edge back
  logic [31:0] cfg_q, cfg_p, base, exp_sp;
  logic        mis, ua, adj, hp;
  assign base   = exc_sp - 32'h20;
  assign exp_sp = cfg_q[9] ? {base[31:3], 3'h0} : {base[31:2], 2'h0};
  assign adj    = cfg_q[9] && base[2];
  assign mis    = (mem_access.size == SZ_HALF) ? mem_access.addr_lo[0] :
                  (mem_access.size == SZ_WORD) && (|mem_access.addr_lo);
  assign ua     = mis && (mem_access.multiple || mem_access.exclusive);
  assign hp     = data_fault.valid && data_fault.high_prio;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_q <= 32'h200;
      cfg_p <= 32'h200;
    end else begin
      cfg_p <= cfg_q;
      if (reg_wr && reg_addr == OFS_CONFIG)
        cfg_q <= reg_wdata & 32'h31b;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  cfg_read_a: assert property (
    reg_rd && reg_addr == OFS_CONFIG |=> reg_rdata == cfg_p)
    else $error("config readback wrong");
  frame_calc_a: assert property (
    exc_entry && !lockup |=> frame_valid && frame_sp == $past(exp_sp)
      && frame_sp_adjusted == $past(adj))
    else $error("frame pointer wrong");
  lockup_hold_a: assert property (
    hp && !cfg_q[8] |=> lockup [*4])
    else $error("lockup missing");
  fault_skip_a: assert property (
    hp && cfg_q[8] && !lockup |=> fault_ignored && !lockup)
    else $error("fault not ignored");
  div_trap_a: assert property (
    div_valid && !lockup |=> div_trap == ($past(div_by_zero) && cfg_p[4]))
    else $error("divide trap wrong");
  unalign_a: assert property (
    mem_access.valid && !lockup
      |=> unaligned_fault == ($past(ua) || ($past(mis) && cfg_p[3])))
    else $error("unaligned fault wrong");
  trig_gate_a: assert property (
    trig_req && trig_unpriv && !lockup
      |=> trig_grant == cfg_p[1] && trig_denied == !cfg_p[1])
    else $error("trigger access wrong");
  thread_gate_a: assert property (
    thread_return && thread_nonbase && !lockup
      |=> thread_fault == !cfg_p[0])
    else $error("thread entry wrong");
  cover property ($rose(lockup));
  cover property (frame_valid && frame_sp_adjusted);
  cover property (unaligned_fault);
endmodule // config_control_props

bind config_control config_control_props props_inst (.*);

// *** tb/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import cfg_ctrl_pkg::*;
  logic        ref_clk, reset, reg_wr, reg_rd, exc_entry, div_valid, irq;
  logic        div_by_zero, trig_req, trig_unpriv, thread_return;
  logic        thread_nonbase, lockup, fault_ignored, div_trap, trig_grant;
  logic        unaligned_fault, trig_denied, thread_fault;
  logic        frame_sp_adjusted, frame_valid;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, exc_sp, frame_sp, r;
  data_fault_s data_fault;
  mem_access_s mem_access;
  int          bad_count, cmp_count;

  config_control config_control_inst (.*);

  always #50 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask
  // Drop every event input after one edge, then let outputs settle
  task automatic fire();
    @(posedge ref_clk);
    exc_entry <= 1'b0;
    div_valid <= 1'b0;
    trig_req <= 1'b0;
    thread_return <= 1'b0;
    data_fault <= '0;
    mem_access <= '0;
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(OFS_CONFIG);
    check("cfg_reset", r, 32'h200);
    wr(OFS_CONFIG, 32'hffff_ffff);
    rd(OFS_CONFIG);
    check("cfg_ones", r, 32'h31b);
    wr(OFS_CONFIG, 32'h0);
    rd(OFS_CONFIG);
    check("cfg_zero", r, 32'h0);
    rd(8'h40);
    check("unmapped", r, 32'h0);
  endtask
  task automatic t_div();
    for (int t = 0; t < 2; t++) begin
      wr(OFS_CONFIG, t ? 32'h10 : 32'h0);
      @(posedge ref_clk);
      div_valid <= 1'b1;
      div_by_zero <= 1'b1;
      fire();
      check("div_trap", div_trap, t);
    end
    rd(OFS_EV_STATUS);
    check("status", r, 32'h4);
    check("irq_masked", irq, 1'b0);
    wr(OFS_EV_MASK, 32'h4);
    #1 check("irq_on", irq, 1'b1);
    wr(OFS_EV_STATUS, 32'h4);
    #1 check("irq_off", irq, 1'b0);
  endtask
  task automatic t_unalign();
    logic [5:0] cs [6] = '{6'h14, 6'h28, 6'h20, 6'h0c, 6'h2a, 6'h15};
    logic       m;
    for (int t = 0; t < 2; t++) begin
      wr(OFS_CONFIG, t ? 32'h8 : 32'h0);
      foreach (cs[i]) begin
        m = (cs[i][5:4] == 2'h1) ? cs[i][2] :
            (cs[i][5:4] == 2'h2) && (|cs[i][3:2]);
        @(posedge ref_clk);
        mem_access <= '{1'b1, cs[i][3:2], access_size_e'(cs[i][5:4]),
                        cs[i][1], cs[i][0]};
        fire();
        check("unaligned", unaligned_fault,
              m && (t || cs[i][1] || cs[i][0]));
      end
    end
  endtask
  task automatic t_trig_thread();
    for (int t = 0; t < 2; t++) begin
      wr(OFS_CONFIG, t ? 32'h3 : 32'h0);
      for (int u = 0; u < 2; u++) begin
        @(posedge ref_clk);
        trig_req <= 1'b1;
        trig_unpriv <= u[0];
        thread_return <= 1'b1;
        thread_nonbase <= u[0];
        fire();
        check("grant", trig_grant, !u || t);
        check("denied", trig_denied, u && !t);
        check("thread", thread_fault, u && !t);
      end
    end
  endtask
  task automatic t_frame();
    logic [31:0] b;
    for (int t = 0; t < 2; t++) begin
      wr(OFS_CONFIG, t ? 32'h200 : 32'h0);
      for (int k = 0; k < 3; k++) begin
        b = 32'h1000 + 32'(3 * k) - 32'h20;
        @(posedge ref_clk);
        exc_entry <= 1'b1;
        exc_sp <= 32'h1000 + 32'(3 * k);
        fire();
        check("frame_sp", frame_sp, t ? b & ~32'h7 : b & ~32'h3);
        check("adjusted", frame_sp_adjusted, t && b[2]);
        check("frame_valid", frame_valid, 1'b1);
      end
    end
  endtask
  task automatic t_fault();
    wr(OFS_CONFIG, 32'h110);
    @(posedge ref_clk);
    data_fault <= '{1'b1, 1'b1};
    fire();
    check("ignored", fault_ignored, 1'b1);
    check("no_lock", lockup, 1'b0);
    wr(OFS_CONFIG, 32'h10);
    @(posedge ref_clk);
    data_fault <= '{1'b1, 1'b1};
    fire();
    check("lockup", lockup, 1'b1);
    // Locked core must swallow later events
    @(posedge ref_clk);
    div_valid <= 1'b1;
    fire();
    check("locked_div", div_trap, 1'b0);
    check("still_locked", lockup, 1'b1);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    rd(OFS_CONFIG);
    check("cfg_rereset", r, 32'h200);
    check("unlocked", lockup, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    {reg_wr, reg_rd, exc_entry, div_valid, div_by_zero} = '0;
    {trig_req, trig_unpriv, thread_return, thread_nonbase} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    exc_sp = '0;
    data_fault = '0;
    mem_access = '0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_div();
    t_unalign();
    t_trig_thread();
    t_frame();
    t_fault();
    report_and_stop();
  end
  // Whole run needs about a hundred cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end
endmodule // testbench
